// ---- design/rtcm_pkg.sv ----
// package: constants, register map and types of the month/year/alarm block
package rtcm_pkg;

    // ==========================================================
    // register map (word index on the plain register port)
    localparam logic [3:0] OFS_MONTH_COUNT   = 4'h0;
    localparam logic [3:0] OFS_YEAR_COUNT    = 4'h1;
    localparam logic [3:0] OFS_SECOND_ALARM  = 4'h2;
    localparam logic [3:0] OFS_MINUTE_ALARM  = 4'h3;
    localparam logic [3:0] OFS_HOUR_ALARM    = 4'h4;
    localparam logic [3:0] OFS_WEEKDAY_ALARM = 4'h5;
    localparam logic [3:0] OFS_DATE_ALARM    = 4'h6;
    localparam logic [3:0] OFS_MONTH_ALARM   = 4'h7;
    localparam logic [3:0] OFS_ALARM_CTRL    = 4'h8;
    localparam logic [3:0] OFS_IRQ_STATUS    = 4'h9;
    localparam logic [3:0] OFS_IRQ_MASK      = 4'ha;

    // ==========================================================
    // field layout
    localparam int          NUM_ALARMS      = 6;
    localparam int          ENB_BIT         = 7;
    localparam int          FLAG_BIT        = 0;
    localparam logic [7:0]  MONTH_MASK      = 8'h1f;
    localparam logic [7:0]  YEAR_MASK       = 8'hff;
    // time-field masks of the alarm registers, ALARM_COMPARE_ENABLE excluded
    localparam logic [6:0]  ALARM_MASK [NUM_ALARMS] = '{
        7'h7f, 7'h7f, 7'h3f, 7'h07, 7'h3f, 7'h1f};

    // interrupt status / mask bits
    localparam int          IRQ_W           = 3;
    localparam int          IRQ_ALARM       = 0;
    localparam int          IRQ_MONTH_WRAP  = 1;
    localparam int          IRQ_YEAR_WRAP   = 2;

    // ==========================================================
    // bcd limits
    localparam logic [7:0]  MONTH_FIRST     = 8'h01;
    localparam logic [7:0]  MONTH_LAST      = 8'h12;
    localparam logic [7:0]  YEAR_LAST       = 8'h99;
    localparam logic [7:0]  YEAR_FIRST      = 8'h00;
    localparam logic [3:0]  DIGIT_MAX       = 4'h9;
    localparam logic [3:0]  DIGIT_ZERO      = 4'h0;
    localparam logic [3:0]  DIGIT_ONE       = 4'h1;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;

    // ==========================================================
    // counter values of the second to date stages, same clock
    typedef struct packed {
        logic [7:0] second;
        logic [7:0] minute;
        logic [7:0] hour;
        logic [7:0] weekday;
        logic [7:0] date;
    } rtcm_time_t;

    // ==========================================================
    // bcd increment without wrap
    function automatic logic [7:0] rtcm_bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] == DIGIT_MAX) begin
            r = {v[7:4] + DIGIT_ONE, DIGIT_ZERO};
        end else begin
            r = {v[7:4], v[3:0] + DIGIT_ONE};
        end
        return r;
    endfunction

endpackage

// ---- design/rtcm_top.sv ----
// month and year calendar counters with the alarm compare registers
//
// Notes on behaviour
// R1 - month counter: 8-bit register, two bcd digits, software writes and reads it
// R2 - month advances once for each end-of-month carry from the date stage
// R3 - software loads month only with 00 to 12; otherwise counting undefined
// R4 - software stops counting with the run bit before writing calendar counters
// R5 - month and year counters keep contents through every reset; no reset value
// R6 - year counter: two bcd digits in eight bits, advances on month carry
// R7 - software loads year only with 00 to 99
// R8 - leap year when year value divisible by four; 00 counts as leap
// R9 - bit 7 of each alarm register enables it; all enabled must match
// R10 - second and minute alarm fields hold bcd 00 to 59 with enable
// R11 - hour alarm field holds 00 to 23; bit 6 reads zero
// R12 - weekday alarm field in bits 2..0 holds 0 to 6; bits 6..3 read zero
// R13 - weekday codes run 0 for sunday up to 6 for saturday
// R14 - date alarm field holds 01 to 31 respecting month lengths
// R15 - power-on reset clears alarm enables; alarm time fields keep contents
// R16 - match sets alarm flag; writing 0 clears it, writing 1 leaves it
// R17 - month alarm holds bcd 01 to 12 plus enable and joins the match
// R18 - compare runs on each counting step, seeing the values it produces
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps

module rtcm_top
    import rtcm_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire rtcm_time_t TIME_IN,
    input  wire logic       COUNT_STEP,
    input  wire logic       DATE_CARRY,
    input  wire logic       RUN,
    output logic      [7:0] MONTH,
    output logic      [7:0] YEAR,
    output logic            LEAP_YEAR,
    output logic            ALARM_FLAG,
    output logic            IRQ
);

    // ==========================================================
    // register decode
    wire logic wr_month   = WR && (ADDR == OFS_MONTH_COUNT);
    wire logic wr_year    = WR && (ADDR == OFS_YEAR_COUNT);
    wire logic wr_ctrl    = WR && (ADDR == OFS_ALARM_CTRL);
    wire logic wr_status  = WR && (ADDR == OFS_IRQ_STATUS);
    wire logic wr_mask    = WR && (ADDR == OFS_IRQ_MASK);

    logic [7:0]           month_q;
    logic [7:0]           month_d;
    logic [7:0]           year_q;
    logic [7:0]           year_d;
    logic                 leap_q;
    logic                 leap_d;
    logic                 flag_q;
    logic                 flag_d;
    logic [IRQ_W-1:0]     status_q;
    logic [IRQ_W-1:0]     status_d;
    logic [IRQ_W-1:0]     mask_q;
    logic [IRQ_W-1:0]     mask_d;
    logic                 irq_q;
    logic [7:0]           rdata_q;
    logic [7:0]           rdata_d;

    // ==========================================================
    // month and year counting
    // counting only while running; a write in the same cycle wins over a step
    wire logic step      = RUN && COUNT_STEP;
    wire logic month_adv = step && DATE_CARRY;                               // R2
    wire logic month_end = (month_q == MONTH_LAST);
    wire logic year_adv  = month_adv && month_end;                           // R6
    wire logic year_end  = (year_q == YEAR_LAST);

    wire logic [7:0] month_inc = month_end ? MONTH_FIRST : rtcm_bcd_inc(month_q);
    wire logic [7:0] year_inc  = year_end ? YEAR_FIRST : rtcm_bcd_inc(year_q);

    assign month_d = wr_month  ? (WDATA & MONTH_MASK) :                      // R1
                     month_adv ? month_inc : month_q;
    assign year_d  = wr_year   ? (WDATA & YEAR_MASK) :                       // R6
                     year_adv  ? year_inc : year_q;

    // divisible by four in bcd: even tens with 0/4/8, odd tens with 2/6
    wire logic ones_048 = (year_d[3:0] == 4'h0) || (year_d[3:0] == 4'h4) ||
                          (year_d[3:0] == 4'h8);
    wire logic ones_26  = (year_d[3:0] == 4'h2) || (year_d[3:0] == 4'h6);
    assign leap_d = year_d[4] ? ones_26 : ones_048;                          // R8

    // no reset on purpose: the calendar must survive every reset
    always_ff @(posedge CLK) begin                                           // R5
        month_q <= month_d;
        year_q  <= year_d;
    end

    // ==========================================================
    // alarm registers: enables reset, time fields keep contents
    logic [NUM_ALARMS-1:0] enb_q;
    logic [6:0]            field_q [NUM_ALARMS];
    logic [NUM_ALARMS-1:0] hit;
    logic [7:0]            cmp_cnt [NUM_ALARMS];
    logic [7:0]            alarm_rd [NUM_ALARMS];

    // the month compare sees the value this step produces
    assign cmp_cnt[0] = TIME_IN.second;
    assign cmp_cnt[1] = TIME_IN.minute;
    assign cmp_cnt[2] = TIME_IN.hour;
    assign cmp_cnt[3] = TIME_IN.weekday;                                     // R13
    assign cmp_cnt[4] = TIME_IN.date;
    assign cmp_cnt[5] = month_d;                                             // R18

    genvar g;
    generate
        for (g = 0; g < NUM_ALARMS; g++) begin : g_alarm
            wire logic wr_al = WR && (ADDR == OFS_SECOND_ALARM + 4'(g));

            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    enb_q[g] <= 1'b0;                                        // R15
                end else if (wr_al) begin
                    enb_q[g] <= WDATA[ENB_BIT];                              // R9
                end
            end

            // reserved bits are never stored, so they read as zero
            always_ff @(posedge CLK) begin
                if (wr_al) begin
                    field_q[g] <= WDATA[6:0] & ALARM_MASK[g];  // R10 R11 R12 R14 R17
                end
            end

            // a disabled register counts as matching
            assign hit[g] = !enb_q[g] ||
                            (field_q[g] == (cmp_cnt[g][6:0] & ALARM_MASK[g])); // R9
            assign alarm_rd[g] = {enb_q[g], field_q[g]};
        end
    endgenerate

    // at least one enable needed, otherwise every step would fire
    wire logic match = step && (&hit) && (|enb_q);                           // R9 R17 R18

    // ==========================================================
    // alarm flag and interrupt
    // a match in the clearing cycle wins over the clear
    assign flag_d = match || (flag_q && !(wr_ctrl && !WDATA[FLAG_BIT]));     // R16

    // year wrap only on 99 to 00, month wrap on every december carry
    wire logic [IRQ_W-1:0] events = {year_adv && year_end, month_adv && month_end, match};
    wire logic [IRQ_W-1:0] clr    = wr_status ? WDATA[IRQ_W-1:0] : '0;
    assign status_d = events | (status_q & ~clr);
    // irq follows a mask write on the same edge, no stale cycle
    assign mask_d   = wr_mask ? WDATA[IRQ_W-1:0] : mask_q;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flag_q   <= 1'b0;
            status_q <= '0;
            mask_q   <= '0;
            irq_q    <= 1'b0;
            leap_q   <= 1'b0;
        end else begin
            flag_q   <= flag_d;                                              // R16
            status_q <= status_d;
            irq_q    <= |(status_d & mask_d);
            leap_q   <= leap_d;                                              // R8
            mask_q   <= mask_d;
        end
    end

    // ==========================================================
    // read path: data stands only in the cycle after the strobe
    always_comb begin
        rdata_d = BYTE_ZERO;
        if (RD) begin
            case (ADDR)
                OFS_MONTH_COUNT:   rdata_d = month_q;                        // R1
                OFS_YEAR_COUNT:    rdata_d = year_q;
                OFS_SECOND_ALARM:  rdata_d = alarm_rd[0];
                OFS_MINUTE_ALARM:  rdata_d = alarm_rd[1];
                OFS_HOUR_ALARM:    rdata_d = alarm_rd[2];                    // R11
                OFS_WEEKDAY_ALARM: rdata_d = alarm_rd[3];                    // R12
                OFS_DATE_ALARM:    rdata_d = alarm_rd[4];
                OFS_MONTH_ALARM:   rdata_d = alarm_rd[5];
                OFS_ALARM_CTRL:    rdata_d = {7'h00, flag_q};
                OFS_IRQ_STATUS:    rdata_d = {5'h00, status_q};
                OFS_IRQ_MASK:      rdata_d = {5'h00, mask_q};
                default:           rdata_d = BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= BYTE_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // outputs
    assign RDATA      = rdata_q;
    assign MONTH      = month_q;
    assign YEAR       = year_q;
    assign LEAP_YEAR  = leap_q;
    assign ALARM_FLAG = flag_q;
    assign IRQ        = irq_q;

endmodule

// ---- dv/rtcm_assertions.sv ----
// checker: port-level assertions of the month/year/alarm block
`timescale 1ns/100ps
module rtcm_checker
    import rtcm_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       COUNT_STEP,
    input wire logic       DATE_CARRY,
    input wire logic       RUN,
    input wire logic [7:0] MONTH,
    input wire logic [7:0] YEAR,
    input wire logic       LEAP_YEAR,
    input wire logic       ALARM_FLAG
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ==========================================================
    // helper: counters unknown until loaded, month is loaded before year
    logic seen_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            seen_q <= 1'b0;
        end else if (WR && ADDR == OFS_YEAR_COUNT) begin
            seen_q <= 1'b1;
        end
    end
    sequence carry_s;
        COUNT_STEP && RUN && DATE_CARRY && !WR && seen_q;
    endsequence
    sequence ctrl_zero_s;
        WR && ADDR == OFS_ALARM_CTRL && !WDATA[FLAG_BIT] && !(COUNT_STEP && RUN);
    endsequence
    // ==========================================================
    // assertions
    rdata_idle_a: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data not zero outside read cycle");
    month_read_a: assert property (seen_q && RD && ADDR == OFS_MONTH_COUNT
        |=> RDATA == $past(MONTH)) else $error("month readback wrong");
    month_hold_a: assert property (seen_q && !(WR && ADDR == OFS_MONTH_COUNT)
        && !(COUNT_STEP && RUN && DATE_CARRY) |=> $stable(MONTH)) else $error("month moved");
    year_hold_a: assert property (seen_q && !(WR && ADDR == OFS_YEAR_COUNT)
        && !(COUNT_STEP && RUN && DATE_CARRY && MONTH == 8'h12) |=> $stable(YEAR))
        else $error("year moved");
    month_step_a: assert property (carry_s ##0 (MONTH[3:0] < 4'h9 && MONTH != 8'h12)
        |=> MONTH == $past(MONTH) + 8'h01) else $error("month did not advance");
    year_wrap_a: assert property (carry_s ##0 (MONTH == 8'h12 && YEAR == 8'h99)
        |=> MONTH == 8'h01 && YEAR == 8'h00 && LEAP_YEAR) else $error("year wrap wrong");
    leap_track_a: assert property (seen_q
        |-> LEAP_YEAR == ((({YEAR[7:4], 1'b0} + 5'(YEAR[3:0])) & 5'h03) == 5'h00))
        else $error("leap year wrong");
    alarm_cause_a: assert property ($rose(ALARM_FLAG) |-> $past(COUNT_STEP && RUN))
        else $error("alarm flag set without step");
    flag_clear_a: assert property (ctrl_zero_s |=> !ALARM_FLAG)
        else $error("alarm flag not cleared");
    flag_hold_a: assert property (ALARM_FLAG && !(WR && ADDR == OFS_ALARM_CTRL
        && !WDATA[FLAG_BIT]) |=> ALARM_FLAG) else $error("alarm flag dropped");
endmodule
bind rtcm_top rtcm_checker chk_u (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .COUNT_STEP(COUNT_STEP), .DATE_CARRY(DATE_CARRY),
    .RUN(RUN), .MONTH(MONTH), .YEAR(YEAR), .LEAP_YEAR(LEAP_YEAR), .ALARM_FLAG(ALARM_FLAG));

// ---- dv/tb_rtc_month_year_alarm_compare.sv ----
// testbench: register, counting, alarm and reset scenarios of the month/year block
`timescale 1ns/100ps
module tb_rtc_month_year_alarm_compare import rtcm_pkg::*; ;
    logic       CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
    logic       COUNT_STEP = 1'b0, DATE_CARRY = 1'b0, RUN = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [7:0] WDATA = 8'h00, RDATA, MONTH, YEAR;
    logic       LEAP_YEAR, ALARM_FLAG, IRQ;
    rtcm_time_t TIME_IN = '0;
    int         error_cnt = 0, samples_checked = 0;
    always #10 CLK = ~CLK;
    rtcm_top dut_u (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .TIME_IN(TIME_IN), .COUNT_STEP(COUNT_STEP), .DATE_CARRY(DATE_CARRY),
        .RUN(RUN), .MONTH(MONTH), .YEAR(YEAR), .LEAP_YEAR(LEAP_YEAR),
        .ALARM_FLAG(ALARM_FLAG), .IRQ(IRQ));
    // ==========================================================
    // shared tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a read compares against d, the expected byte
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR <= w;
        RD <= ~w;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b0;
        #1;
        if (!w) chk8(RDATA, d);
    endtask
    task automatic step(input rtcm_time_t t, input logic c, input logic r);
        @(posedge CLK);
        TIME_IN <= t;
        COUNT_STEP <= 1'b1;
        DATE_CARRY <= c;
        RUN <= r;
        @(posedge CLK);
        COUNT_STEP <= 1'b0;
        DATE_CARRY <= 1'b0;
        RUN <= 1'b0;
        #1;
    endtask
    task automatic close_out();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic test_regs();
        logic [3:0] a [10] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'h1, 4'h0, 4'hb};
        logic [7:0] d [10] = '{8'hd9, 8'ha7, 8'he3, 8'hfe, 8'hf1, 8'hf2, 8'he9, 8'h99,
                               8'h12, 8'h55};
        logic [7:0] e [10] = '{8'hd9, 8'ha7, 8'ha3, 8'h86, 8'hb1, 8'h92, 8'h09, 8'h99,
                               8'h12, 8'h00};
        for (int i = 8; i < 11; i++) bus(1'b0, 4'(i), 8'h00);
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, a[i], d[i]);
            bus(1'b0, a[i], e[i]);
        end
    endtask
    task automatic test_wrap();
        logic [7:0] y [6] = '{8'h00, 8'h04, 8'h96, 8'h01, 8'h10, 8'h98};
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, OFS_YEAR_COUNT, y[i]);
            chk8({7'h00, LEAP_YEAR}, {7'h00, i < 3});
        end
        bus(1'b1, OFS_YEAR_COUNT, 8'h99);
        step('0, 1'b1, 1'b1);
        chk8(MONTH, 8'h01);
        chk8({YEAR[6:0], LEAP_YEAR}, 8'h01);
        bus(1'b0, OFS_IRQ_STATUS, 8'h06);
        bus(1'b1, OFS_IRQ_MASK, 8'h02);
        bus(1'b1, OFS_IRQ_STATUS, 8'h04);
        chk8({7'h00, IRQ}, 8'h01);
        bus(1'b1, OFS_IRQ_STATUS, 8'h02);
        bus(1'b0, OFS_IRQ_STATUS, 8'h00);
        chk8({7'h00, IRQ}, 8'h00);
        // a december carry outside year 99 raises the month wrap bit alone
        bus(1'b1, OFS_MONTH_COUNT, 8'h12);
        step('0, 1'b1, 1'b1);
        chk8({YEAR[6:0], LEAP_YEAR}, 8'h02);
        bus(1'b0, OFS_IRQ_STATUS, 8'h02);
        bus(1'b1, OFS_IRQ_STATUS, 8'h02);
        step('0, 1'b1, 1'b0);
        chk8(MONTH, 8'h01);
        step('0, 1'b1, 1'b1);
        chk8(MONTH, 8'h02);
    endtask
    task automatic test_alarm();
        rtcm_time_t t = '{8'h30, 8'h15, 8'h23, 8'h06, 8'h27};
        logic [7:0] v [6] = '{8'hb0, 8'h95, 8'ha3, 8'h86, 8'ha8, 8'h82};
        for (int i = 0; i < 6; i++) bus(1'b1, OFS_SECOND_ALARM + 4'(i), v[i]);
        bus(1'b1, OFS_IRQ_MASK, 8'h01);
        step(t, 1'b0, 1'b1);
        chk8({6'h00, IRQ, ALARM_FLAG}, 8'h00);
        t.date = 8'h28;
        step(t, 1'b0, 1'b0);
        chk8({7'h00, ALARM_FLAG}, 8'h00);
        step(t, 1'b0, 1'b1);
        chk8({6'h00, IRQ, ALARM_FLAG}, 8'h03);
        bus(1'b1, OFS_ALARM_CTRL, 8'h01);
        chk8({7'h00, ALARM_FLAG}, 8'h01);
        bus(1'b1, OFS_ALARM_CTRL, 8'h00);
        bus(1'b1, OFS_IRQ_STATUS, 8'h01);
        chk8({6'h00, IRQ, ALARM_FLAG}, 8'h00);
        bus(1'b1, OFS_WEEKDAY_ALARM, 8'h06);
        t.weekday = 8'h02;
        step(t, 1'b0, 1'b1);
        chk8({7'h00, ALARM_FLAG}, 8'h01);
    endtask
    // second reset with the flag up: enables and flag clear, counters and fields stay
    task automatic test_reset();
        @(posedge CLK);
        RST <= 1'b1;
        @(posedge CLK);
        RST <= 1'b0;
        #1;
        chk8({6'h00, IRQ, ALARM_FLAG}, 8'h00);
        bus(1'b0, OFS_SECOND_ALARM, 8'h30);
        bus(1'b0, OFS_MONTH_ALARM, 8'h02);
        bus(1'b0, OFS_MONTH_COUNT, 8'h02);
        bus(1'b0, OFS_YEAR_COUNT, 8'h01);
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        test_regs();
        test_wrap();
        test_alarm();
        test_reset();
        close_out();
    end
    initial begin
        #200000;
        error_cnt++;
        close_out();
    end
endmodule
